// File: core/fsl_pkg.sv
package fsl_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_WE_LOW_NS   = 50;
  localparam int T_WE_HIGH_NS  = 30;
  localparam int T_OE_NS       = 100;
  localparam int SYNC_CYC      = 2;
  localparam int WE_LOW_CYC  =
    (T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_HIGH_CYC =
    (T_WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OE_CYC      =
    (T_OE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_CYC;

  localparam int AXI_AW   = 4;
  localparam int FLASH_AW = 21;
  localparam int FLASH_DW = 16;

  localparam logic [AXI_AW-1:0] OFS_CMD  = 4'h0;
  localparam logic [AXI_AW-1:0] OFS_ADDR = 4'h4;
  localparam logic [AXI_AW-1:0] OFS_PINS = 4'h8;
  localparam logic [AXI_AW-1:0] OFS_STAT = 4'hC;

  localparam int PIN_WP   = 0;
  localparam int PIN_BYTE = 1;
  localparam logic [1:0] PINS_RST = 2'h2;

  localparam int SR_READY  = 7;
  localparam int SR_ESUSP  = 6;
  localparam int SR_ECERR  = 5;
  localparam int SR_PSERR  = 4;
  localparam int SR_LOWV   = 3;
  localparam int SR_PSUSP  = 2;
  localparam int SR_PABORT = 1;

  localparam int ST_BUSY  = 8;
  localparam int ST_ESUSP = 9;
  localparam int ST_PSUSP = 10;
  localparam int ST_LKERR = 11;
  localparam int ST_LKUNK = 12;
  localparam int ST_STS   = 13;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [7:0] CMD_RDSR_DEF       = 8'h70;
  localparam logic [7:0] CMD_CLRSR_DEF      = 8'h50;
  localparam logic [7:0] CMD_SUSP_DEF       = 8'hB0;
  localparam logic [7:0] CMD_RESUME_DEF     = 8'hD0;
  localparam logic [7:0] CMD_LOCK_SETUP_DEF = 8'h60;
  localparam logic [7:0] CMD_LOCK_SET_DEF   = 8'h01;
  localparam logic [7:0] CMD_LOCK_CLR_DEF   = 8'hD0;

  typedef enum logic [2:0] {
    OP_RDSR  = 3'h0,
    OP_ESUSP = 3'h1,
    OP_ERES  = 3'h2,
    OP_PSUSP = 3'h3,
    OP_PRES  = 3'h4,
    OP_LSET  = 3'h5,
    OP_LCLR  = 3'h6,
    OP_CLRSR = 3'h7
  } fsl_op_e;

  typedef enum logic [2:0] {
    S_IDLE    = 3'h0,
    S_WE_LOW  = 3'h1,
    S_WE_HIGH = 3'h3,
    S_OE_WAIT = 3'h2,
    S_EVAL    = 3'h6
  } fsl_state_e;

  typedef struct packed {
    logic [FLASH_AW-1:0] addr;
    logic [FLASH_DW-1:0] dq;
    logic                dq_oe_n;
    logic                ce_n;
    logic                we_n;
    logic                oe_n;
    logic                rp_n;
    logic                wp_n;
    logic                byte_n;
  } fsl_flash_s;
endpackage

// File: core/fsl_host.sv
// Behaviour
// - Host keeps reset pin inactive, write-protect and width fixed in suspend.
// - Host keeps reset, write-protect and width unchanged in program suspend.
// - Lock set is setup write then confirm write within block.
// - Clear-locks is setup then confirm; clears all lock bits together.
// - Interrupted clear-locks leaves locks undefined; host must repeat it.
// - After clear-locks host checks clear error and clears status if set.
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
module fsl_host #(
  parameter logic [7:0] CMD_RDSR       = fsl_pkg::CMD_RDSR_DEF,
  parameter logic [7:0] CMD_CLRSR      = fsl_pkg::CMD_CLRSR_DEF,
  parameter logic [7:0] CMD_SUSP       = fsl_pkg::CMD_SUSP_DEF,
  parameter logic [7:0] CMD_RESUME     = fsl_pkg::CMD_RESUME_DEF,
  parameter logic [7:0] CMD_LOCK_SETUP = fsl_pkg::CMD_LOCK_SETUP_DEF,
  parameter logic [7:0] CMD_LOCK_SET   = fsl_pkg::CMD_LOCK_SET_DEF,
  parameter logic [7:0] CMD_LOCK_CLR   = fsl_pkg::CMD_LOCK_CLR_DEF
) (
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  input  wire logic                        clk_en,
  input  wire logic [fsl_pkg::AXI_AW-1:0]  awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  input  wire logic [fsl_pkg::AXI_AW-1:0]  araddr,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  output fsl_pkg::fsl_flash_s              flash_o,
  input  wire logic [fsl_pkg::FLASH_DW-1:0] dq_in,
  input  wire logic                        sts_in
);
  import fsl_pkg::*;

  fsl_flash_s          fo_reg, fo_next;
  fsl_state_e          st_reg, st_next;
  fsl_op_e             op_reg, op_next, cmd_op_reg, cmd_op_next;
  logic [7:0]          cnt_reg, cnt_next, sr_reg, sr_next;
  logic                step_reg, step_next, busy_reg, busy_next;
  logic                es_reg, es_next, ps_reg, ps_next;
  logic                lkerr_reg, lkerr_next, lkunk_reg, lkunk_next;
  logic                start_reg, start_next, wrdy_reg, wrdy_next;
  logic                bvalid_reg, bvalid_next, ard_reg, ard_next;
  logic                rvalid_reg, rvalid_next;
  logic [1:0]          bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [1:0]          pins_reg, pins_next;
  logic [31:0]         addr_reg, addr_next, rdata_reg, rdata_next;
  logic [FLASH_DW-1:0] dq_s1, dq_s2;
  logic                sts_s1, sts_s2, polls, wr_hs, rd_hs, locked_cfg;

  localparam fsl_flash_s FO_RST = '{addr: '0, dq: '0, dq_oe_n: 1'b1,
    ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, rp_n: 1'b1, wp_n: 1'b0,
    byte_n: 1'b1};

  assign flash_o = fo_reg;
  assign awready = wrdy_reg;
  assign wready  = wrdy_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign arready = ard_reg;
  assign rvalid  = rvalid_reg;
  assign rresp   = rresp_reg;
  assign rdata   = rdata_reg;

  function automatic logic [7:0] cmd_byte(fsl_op_e op, logic step);
    logic [7:0] b;
    b = CMD_RDSR;
    unique case (op)
      OP_RDSR:           b = CMD_RDSR;
      OP_ESUSP, OP_PSUSP: b = CMD_SUSP;
      OP_ERES, OP_PRES:  b = CMD_RESUME;
      OP_LSET:           b = step ? CMD_LOCK_SET : CMD_LOCK_SETUP;
      OP_LCLR:           b = step ? CMD_LOCK_CLR : CMD_LOCK_SETUP;
      OP_CLRSR:          b = CMD_CLRSR;
    endcase
    return b;
  endfunction

  assign wr_hs = wrdy_reg && awvalid && wvalid;
  assign rd_hs = ard_reg && arvalid;
  // Pins stay put while any operation or suspension is open
  assign locked_cfg = busy_reg || start_reg || es_reg || ps_reg;

  always_comb begin
    wrdy_next   = awvalid && wvalid && !wrdy_reg && !bvalid_reg;
    bvalid_next = bvalid_reg;
    bresp_next  = bresp_reg;
    ard_next    = arvalid && !ard_reg && !rvalid_reg;
    rvalid_next = rvalid_reg;
    rresp_next  = rresp_reg;
    rdata_next  = rdata_reg;
    start_next  = 1'b0;
    cmd_op_next = cmd_op_reg;
    addr_next   = addr_reg;
    pins_next   = pins_reg;
    if (bvalid_reg && bready) begin
      bvalid_next = 1'b0;
    end
    if (wr_hs) begin
      bvalid_next = 1'b1;
      bresp_next  = RESP_OKAY;
      unique case (awaddr)
        OFS_CMD: begin
          if (!busy_reg && !start_reg) begin
            start_next  = 1'b1;
            cmd_op_next = fsl_op_e'(wdata[2:0]);
          end
        end
        OFS_ADDR: begin
          for (int i = 0; i < 4; i++) begin
            if (wstrb[i]) begin
              addr_next[8*i +: 8] = wdata[8*i +: 8];
            end
          end
        end
        OFS_PINS: begin
          if (!locked_cfg) begin
            pins_next = wdata[1:0];
          end
        end
        OFS_STAT: bresp_next = RESP_OKAY;
        default:  bresp_next = RESP_SLVERR;
      endcase
    end
    if (rvalid_reg && rready) begin
      rvalid_next = 1'b0;
    end
    if (rd_hs) begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OKAY;
      rdata_next  = '0;
      unique case (araddr)
        OFS_CMD:  rdata_next[2:0] = cmd_op_reg;
        OFS_ADDR: rdata_next = addr_reg;
        OFS_PINS: rdata_next[1:0] = pins_reg;
        OFS_STAT: begin
          rdata_next[7:0]      = sr_reg;
          rdata_next[ST_BUSY]  = busy_reg || start_reg;
          rdata_next[ST_ESUSP] = es_reg;
          rdata_next[ST_PSUSP] = ps_reg;
          rdata_next[ST_LKERR] = lkerr_reg;
          rdata_next[ST_LKUNK] = lkunk_reg;
          rdata_next[ST_STS]   = sts_s2;
        end
        default: rresp_next = RESP_SLVERR;
      endcase
    end
  end

  assign polls = op_reg inside {OP_ESUSP, OP_PSUSP, OP_LSET, OP_LCLR};

  always_comb begin
    st_next        = st_reg;
    cnt_next       = cnt_reg;
    step_next      = step_reg;
    op_next        = op_reg;
    fo_next        = fo_reg;
    sr_next        = sr_reg;
    busy_next      = busy_reg;
    es_next        = es_reg;
    ps_next        = ps_reg;
    lkerr_next     = lkerr_reg;
    lkunk_next     = lkunk_reg;
    fo_next.rp_n   = 1'b1;
    fo_next.wp_n   = pins_reg[PIN_WP];
    fo_next.byte_n = pins_reg[PIN_BYTE];
    unique case (st_reg)
      S_IDLE: begin
        if (start_reg) begin
          op_next         = cmd_op_reg;
          step_next       = 1'b0;
          cnt_next        = '0;
          busy_next       = 1'b1;
          fo_next.addr    = addr_reg[FLASH_AW-1:0];
          fo_next.dq      = {8'h00, cmd_byte(cmd_op_reg, 1'b0)};
          fo_next.dq_oe_n = 1'b0;
          fo_next.ce_n    = 1'b0;
          fo_next.we_n    = 1'b0;
          fo_next.oe_n    = 1'b1;
          st_next         = S_WE_LOW;
          if (cmd_op_reg inside {OP_LSET, OP_LCLR}) begin
            lkerr_next = 1'b0;
          end
          if (cmd_op_reg == OP_LCLR) begin
            lkunk_next = 1'b1;
          end
        end
      end
      S_WE_LOW: begin
        if (cnt_reg == 8'(WE_LOW_CYC - 1)) begin
          fo_next.we_n = 1'b1;
          cnt_next     = '0;
          st_next      = S_WE_HIGH;
        end else begin
          cnt_next = cnt_reg + 8'h01;
        end
      end
      S_WE_HIGH: begin
        if (cnt_reg == 8'(WE_HIGH_CYC - 1)) begin
          cnt_next = '0;
          if (op_reg inside {OP_LSET, OP_LCLR} && !step_reg) begin
            step_next    = 1'b1;
            fo_next.dq   = {8'h00, cmd_byte(op_reg, 1'b1)};
            fo_next.we_n = 1'b0;
            st_next      = S_WE_LOW;
          end else if (op_reg == OP_CLRSR) begin
            fo_next.dq_oe_n = 1'b1;
            fo_next.ce_n    = 1'b1;
            busy_next       = 1'b0;
            st_next         = S_IDLE;
          end else begin
            fo_next.dq_oe_n = 1'b1;
            fo_next.oe_n    = 1'b0;
            st_next         = S_OE_WAIT;
          end
        end else begin
          cnt_next = cnt_reg + 8'h01;
        end
      end
      S_OE_WAIT: begin
        if (cnt_reg == 8'(OE_CYC - 1)) begin
          sr_next  = dq_s2[7:0];
          cnt_next = '0;
          st_next  = S_EVAL;
        end else begin
          cnt_next = cnt_reg + 8'h01;
        end
      end
      S_EVAL: begin
        if (polls && !sr_reg[SR_READY]) begin
          st_next = S_OE_WAIT;
        end else begin
          fo_next.ce_n = 1'b1;
          fo_next.oe_n = 1'b1;
          busy_next    = 1'b0;
          st_next      = S_IDLE;
          unique case (op_reg)
            OP_ESUSP: es_next = sr_reg[SR_ESUSP];
            OP_PSUSP: ps_next = sr_reg[SR_PSUSP];
            OP_ERES:  es_next = sr_reg[SR_ESUSP];
            OP_PRES:  ps_next = sr_reg[SR_PSUSP];
            default:  es_next = es_reg;
          endcase
          if (op_reg inside {OP_LSET, OP_LCLR}) begin
            lkerr_next = sr_reg[SR_ECERR] || sr_reg[SR_PSERR] ||
                         sr_reg[SR_LOWV] || sr_reg[SR_PABORT];
          end
          if (op_reg == OP_LCLR) begin
            lkunk_next = sr_reg[SR_ECERR];
            if (sr_reg[SR_ECERR]) begin
              op_next         = OP_CLRSR;
              step_next       = 1'b0;
              fo_next.dq      = {8'h00, CMD_CLRSR};
              fo_next.dq_oe_n = 1'b0;
              fo_next.ce_n    = 1'b0;
              fo_next.we_n    = 1'b0;
              busy_next       = 1'b1;
              st_next         = S_WE_LOW;
            end
          end
        end
      end
      default: st_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fo_reg <= FO_RST;      st_reg <= S_IDLE;      op_reg <= OP_RDSR;
      cmd_op_reg <= OP_RDSR; cnt_reg <= '0;         sr_reg <= '0;
      step_reg <= 1'b0;      busy_reg <= 1'b0;      es_reg <= 1'b0;
      ps_reg <= 1'b0;        lkerr_reg <= 1'b0;     lkunk_reg <= 1'b0;
      start_reg <= 1'b0;     wrdy_reg <= 1'b0;      bvalid_reg <= 1'b0;
      ard_reg <= 1'b0;       rvalid_reg <= 1'b0;    bresp_reg <= RESP_OKAY;
      rresp_reg <= RESP_OKAY; pins_reg <= PINS_RST; addr_reg <= '0;
      rdata_reg <= '0;       dq_s1 <= '0;           dq_s2 <= '0;
      sts_s1 <= 1'b0;        sts_s2 <= 1'b0;
    end else if (clk_en) begin
      fo_reg <= fo_next;      st_reg <= st_next;      op_reg <= op_next;
      cmd_op_reg <= cmd_op_next; cnt_reg <= cnt_next; sr_reg <= sr_next;
      step_reg <= step_next;  busy_reg <= busy_next;  es_reg <= es_next;
      ps_reg <= ps_next;      lkerr_reg <= lkerr_next; lkunk_reg <= lkunk_next;
      start_reg <= start_next; wrdy_reg <= wrdy_next;
      bvalid_reg <= bvalid_next; ard_reg <= ard_next;
      rvalid_reg <= rvalid_next; bresp_reg <= bresp_next;
      rresp_reg <= rresp_next; pins_reg <= pins_next; addr_reg <= addr_next;
      rdata_reg <= rdata_next; dq_s1 <= dq_in;        dq_s2 <= dq_s1;
      sts_s1 <= sts_in;       sts_s2 <= sts_s1;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset || !clk_en);

  a_rp_inactive: assert property (fo_reg.rp_n)
    else $error("reset pin driven active");
  a_wp_frozen: assert property ((es_reg || ps_reg) && $past(es_reg || ps_reg)
    |-> fo_reg.wp_n == $past(fo_reg.wp_n))
    else $error("write-protect moved during suspension");
  a_byte_frozen: assert property (ps_reg && $past(ps_reg)
    |-> fo_reg.byte_n == $past(fo_reg.byte_n))
    else $error("width select moved during suspension");
  a_lock_confirm: assert property (st_reg == S_WE_HIGH && !step_reg &&
    op_reg inside {OP_LSET, OP_LCLR} && cnt_reg == 8'(WE_HIGH_CYC - 1)
    |=> st_reg == S_WE_LOW && step_reg && !fo_reg.we_n)
    else $error("lock confirm write did not follow setup");
  a_we_pulse: assert property ($fell(fo_reg.we_n)
    |-> (!fo_reg.we_n && !fo_reg.dq_oe_n && !fo_reg.ce_n)[*5])
    else $error("write strobe too short or data not driven");
  a_clr_confirm: assert property (st_reg == S_WE_LOW && op_reg == OP_LCLR
    && step_reg |-> fo_reg.dq[7:0] == CMD_LOCK_CLR)
    else $error("wrong clear confirm byte");
  a_unknown_mark: assert property (st_reg == S_IDLE && start_reg &&
    cmd_op_reg == OP_LCLR |=> lkunk_reg && busy_reg)
    else $error("lock state not marked unknown");
  a_auto_clear: assert property (st_reg == S_EVAL && op_reg == OP_LCLR &&
    sr_reg[SR_READY] && sr_reg[SR_ECERR] |=> op_reg == OP_CLRSR &&
    st_reg == S_WE_LOW && fo_reg.dq[7:0] == CMD_CLRSR)
    else $error("clear-status not issued after clear error");
endmodule

// File: testbench/fsl_flash_model.sv
`timescale 1ns/100ps
module fsl_flash_model (
  input  wire logic                    clk_sys,
  input  wire fsl_pkg::fsl_flash_s     flash_o,
  input  wire logic                    vpp_ok,
  input  wire logic [9:0]              susp_lat,
  input  wire logic                    erase_go,
  input  wire logic                    prog_go,
  output logic [fsl_pkg::FLASH_DW-1:0] dq_in,
  output logic                         sts_in
);
  import fsl_pkg::*;
  logic [7:0]  sr = 8'h00;
  logic [31:0] locks = 32'h0;
  logic [9:0]  e_left = 10'h0, p_left = 10'h0, l_left = 10'h0, s_cnt = 10'h0;
  logic        esusp = 1'b0, psusp = 1'b0, setup = 1'b0, we_q = 1'b1;
  logic [15:0] last = 16'h0;
  logic        busy, e_run, p_run;
  logic [7:0]  cmd;
  logic [4:0]  blk;
  assign cmd = flash_o.dq[7:0];
  assign blk = flash_o.addr[20:16];
  assign e_run = e_left != 10'h0 && !esusp;
  assign p_run = p_left != 10'h0 && !psusp;
  assign busy = e_run || p_run || l_left != 10'h0;
  // Released pin reads high through the board pull-up
  assign sts_in = !busy;
  always_comb begin
    if (!flash_o.ce_n && !flash_o.oe_n) begin
      dq_in = {8'h00, !busy, esusp, sr[5:3], psusp, sr[1:0]};
    end else begin
      dq_in = ~last;
    end
  end
  always @(posedge clk_sys) begin
    we_q <= flash_o.we_n;
    if (!flash_o.ce_n && !flash_o.oe_n) last <= dq_in;
    if (e_run) e_left <= e_left - 10'h1;
    if (p_run) p_left <= p_left - 10'h1;
    if (l_left != 10'h0) l_left <= l_left - 10'h1;
    if (s_cnt != 10'h0) s_cnt <= s_cnt - 10'h1;
    if (s_cnt == 10'h1 && p_left != 10'h0) psusp <= 1'b1;
    else if (s_cnt == 10'h1 && e_left != 10'h0) esusp <= 1'b1;
    if (erase_go) e_left <= 10'd400;
    if (prog_go && locks[blk] && !flash_o.wp_n)
      sr[4:1] <= sr[4:1] | 4'h9;
    else if (prog_go && (esusp || !busy)) p_left <= 10'd300;
    if (!flash_o.rp_n && l_left != 10'h0) locks <= 32'hX;
    if (!we_q && flash_o.we_n && !flash_o.ce_n) begin
      setup <= 1'b0;
      if (setup && cmd == CMD_LOCK_SET_DEF) begin
        if (!flash_o.wp_n) sr[4:1] <= sr[4:1] | 4'h9;
        else begin
          locks[blk] <= 1'b1;
          l_left <= 10'd30;
        end
      end else if (setup && cmd == CMD_LOCK_CLR_DEF) begin
        if (!vpp_ok) sr[5:3] <= sr[5:3] | 3'h5;
        else if (!flash_o.wp_n) sr[5:1] <= sr[5:1] | 5'h11;
        else begin
          locks <= 32'h0;
          l_left <= 10'd40;
        end
      end else if (setup) sr[5:4] <= 2'h3;
      else if (cmd == CMD_LOCK_SETUP_DEF) setup <= 1'b1;
      else if (cmd == CMD_CLRSR_DEF) sr <= 8'h00;
      else if (cmd == CMD_SUSP_DEF) s_cnt <= susp_lat + 10'h1;
      else if (cmd == CMD_RESUME_DEF && psusp) psusp <= 1'b0;
      else if (cmd == CMD_RESUME_DEF && p_left == 10'h0)
        esusp <= 1'b0;
      // Any other command leaves the state alone
    end
  end
endmodule

// File: testbench/flash_suspend_lock_commands_tb.sv
`timescale 1ns/100ps
module flash_suspend_lock_commands_tb;
  import fsl_pkg::*;
  logic                clk_sys = 1'b0, reset = 1'b1;
  logic [AXI_AW-1:0]   awaddr = 4'h0, araddr = 4'h0;
  logic [31:0]         wdata = 32'h0, rdata, rd;
  logic                awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                arvalid = 1'b0, rready = 1'b0;
  logic                awready, wready, bvalid, arready, rvalid, sts_in;
  logic [1:0]          bresp, rresp, rsp;
  fsl_flash_s          flash_o;
  logic [FLASH_DW-1:0] dq_in;
  logic                vpp_ok = 1'b1, erase_go = 1'b0, prog_go = 1'b0;
  logic [9:0]          susp_lat = 10'h0;
  int                  miscompares = 0, samples_checked = 0, cyc = 0;

  always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

  fsl_host dut_u (.clk_sys(clk_sys), .reset(reset), .clk_en(1'b1),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .flash_o(flash_o), .dq_in(dq_in), .sts_in(sts_in));

  fsl_flash_model fm_u (.clk_sys(clk_sys), .flash_o(flash_o),
    .vpp_ok(vpp_ok), .susp_lat(susp_lat), .erase_go(erase_go),
    .prog_go(prog_go), .dq_in(dq_in), .sts_in(sts_in));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_t;
    logic w_t;
    aw_t = 1'b0;
    w_t = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_t && w_t)) begin
      @(posedge clk_sys);
      if (awready === 1'b1 && !aw_t) begin
        awvalid <= 1'b0;
        aw_t = 1'b1;
      end
      if (wready === 1'b1 && !w_t) begin
        wvalid <= 1'b0;
        w_t = 1'b1;
      end
    end
    do @(posedge clk_sys); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic axi_rd(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic sr_op(input logic [2:0] op, input logic [13:0] exp);
    axi_wr(OFS_CMD, {29'h0, op});
    do axi_rd(OFS_STAT); while (rd[ST_BUSY] !== 1'b0);
    chk({rsp, 18'h0, rd[13:0]}, {RESP_OKAY, 18'h0, exp});
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    axi_rd(OFS_PINS);
    chk({rsp, rd}, {RESP_OKAY, 30'h0, PINS_RST});
    axi_rd(4'h2);
    chk({rsp, rd}, {RESP_SLVERR, 32'h0});
    axi_wr(4'h6, 32'h1);
    chk({rsp, 32'h0}, {RESP_SLVERR, 32'h0});
    $display("test registers done");
    axi_wr(OFS_PINS, 32'h3);
    axi_wr(OFS_ADDR, 32'h30000);
    susp_lat <= 10'd40;
    erase_go <= 1'b1;
    @(posedge clk_sys);
    erase_go <= 1'b0;
    sr_op(OP_ESUSP, 14'h22C0);
    axi_wr(OFS_PINS, 32'h2);
    axi_rd(OFS_PINS);
    chk({rsp, rd}, {RESP_OKAY, 32'h3});
    $display("test erase suspend done");
    susp_lat <= 10'h0;
    prog_go <= 1'b1;
    @(posedge clk_sys);
    prog_go <= 1'b0;
    sr_op(OP_PSUSP, 14'h26C4);
    chk({32'h0, flash_o.rp_n, flash_o.wp_n}, 34'h3);
    sr_op(OP_RDSR, 14'h26C4);
    sr_op(OP_PRES, 14'h0240);
    sr_op(OP_ERES, 14'h0240);
    axi_wr(OFS_PINS, 32'h2);
    axi_rd(OFS_PINS);
    chk({rsp, rd}, {RESP_OKAY, 32'h3});
    repeat (320) @(posedge clk_sys);
    sr_op(OP_RDSR, 14'h22C0);
    sr_op(OP_ERES, 14'h0000);
    repeat (420) @(posedge clk_sys);
    sr_op(OP_RDSR, 14'h2080);
    $display("test resume done");
    sr_op(OP_LSET, 14'h2080);
    chk({33'h0, fm_u.locks[3]}, 34'h1);
    axi_wr(OFS_PINS, 32'h2);
    sr_op(OP_LSET, 14'h2892);
    sr_op(OP_CLRSR, 14'h2892);
    sr_op(OP_LCLR, 14'h38A2);
    chk({26'h0, fm_u.sr}, 34'h0);
    $display("test lock set done");
    axi_wr(OFS_PINS, 32'h3);
    vpp_ok <= 1'b0;
    sr_op(OP_LCLR, 14'h38A8);
    chk({33'h0, fm_u.locks[3]}, 34'h1);
    vpp_ok <= 1'b1;
    sr_op(OP_LCLR, 14'h2080);
    chk({2'h0, fm_u.locks}, 34'h0);
    axi_rd(OFS_CMD);
    chk({rsp, rd}, {RESP_OKAY, 32'h6});
    $display("test lock clear done");
    end_sim();
  end
endmodule
